/* hw/pfcs_map.vh */
`ifndef PFCS_MAP_VH
`define PFCS_MAP_VH
// ==========================================================
// Pin widths
`define PFCS_AW            19
`define PFCS_DW            16
// ==========================================================
// Unlock and command cycle addresses and data
`define PFCS_UNLOCK_A1     19'h05555
`define PFCS_UNLOCK_A2     19'h02AAA
`define PFCS_UNLOCK_D1     16'h00AA
`define PFCS_UNLOCK_D2     16'h0055
`define PFCS_CMD_PROGRAM   16'h00A0
`define PFCS_CMD_ERASE     16'h0080
`define PFCS_CMD_CHIP      16'h0010
`define PFCS_CMD_SECTOR    16'h0030
`define PFCS_CMD_BLOCK     16'h0050
`define PFCS_CHIP_ADDR     19'h05555
// ==========================================================
// Operation codes on the request port
`define PFCS_OP_READ       3'h0
`define PFCS_OP_PROGRAM    3'h1
`define PFCS_OP_SECTOR     3'h2
`define PFCS_OP_BLOCK      3'h3
`define PFCS_OP_CHIP       3'h4
// ==========================================================
// Status bit positions
`define PFCS_POLL_BIT      7
`define PFCS_TOGGLE_BIT    6
// ==========================================================
// Bus timing (ns) and cycle counts at 100 ns clock
`define PFCS_CLK_NS        100
`define PFCS_T_STROBE_NS   100
`define PFCS_T_READ_NS     200
`define PFCS_STROBE_CYC    ((`PFCS_T_STROBE_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`define PFCS_READ_CYC      ((`PFCS_T_READ_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
// Extra read cycles for the three-stage data synchroniser
`define PFCS_SYNC_CYC      3
// Longest wait for status before giving up (ns): chip erase worst
`define PFCS_T_TIMEOUT_NS  200000000
`define PFCS_TIMEOUT_CYC   (`PFCS_T_TIMEOUT_NS / `PFCS_CLK_NS)
`endif

/* hw/pfcs_sync.v */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Three-stage input synchroniser, change accepted when last two agree
module pfcs_sync #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  // Data
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q     <= {W{1'b0}};
      s2_q     <= {W{1'b0}};
      s3_q     <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_out <= s3_q;
      end
    end
  end
endmodule // pfcs_sync
`default_nettype wire

/* hw/pfcs_host.v */
`timescale 1ns/1ns
`default_nettype none
`include "pfcs_map.vh"
module pfcs_host #(
  parameter [31:0] TIMEOUT_CYC = `PFCS_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire                 ref_clk,
  input  wire                 rst,
  // User request
  input  wire                 req_valid,
  input  wire [2:0]           req_op,
  input  wire [`PFCS_AW-1:0]  req_addr,
  input  wire [`PFCS_DW-1:0]  req_data,
  output reg                  req_ready,
  // User answer
  output reg                  rsp_valid,
  output reg  [`PFCS_DW-1:0]  rsp_data,
  output reg                  rsp_error,
  // Flash pins
  output reg                  flash_ce_n,
  output reg                  flash_oe_n,
  output reg                  flash_we_n,
  output reg  [`PFCS_AW-1:0]  flash_addr,
  output reg  [`PFCS_DW-1:0]  flash_dq_o,
  output reg                  flash_dq_oe,
  input  wire [`PFCS_DW-1:0]  flash_dq_i
);
  // ==========================================================
  // States
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_SETUP  = 4'h1;
  localparam [3:0] ST_STROBE = 4'h2;
  localparam [3:0] ST_HOLD   = 4'h3;
  localparam [3:0] ST_RSETUP = 4'h4;
  localparam [3:0] ST_RWAIT  = 4'h5;
  localparam [3:0] ST_RDONE  = 4'h6;
  localparam [3:0] ST_POLL   = 4'h7;
  localparam [3:0] ST_DONE   = 4'h8;
  localparam integer STROBE_N = `PFCS_STROBE_CYC;
  localparam integer READ_N   = `PFCS_READ_CYC + `PFCS_SYNC_CYC;
  localparam [7:0] STROBE_CYC = STROBE_N[7:0];
  localparam [7:0] READ_CYC   = READ_N[7:0];

  reg [3:0]          state_q;
  reg [2:0]          op_q;
  reg [2:0]          cyc_q;
  reg [7:0]          cnt_q;
  reg [31:0]         tmo_q;
  reg [`PFCS_AW-1:0] addr_q;
  reg [`PFCS_DW-1:0] data_q;
  reg                polling_q;
  reg [1:0]          confirm_q;
  reg [`PFCS_DW-1:0] prev_q;
  reg                prev_ok_q;
  wire [`PFCS_DW-1:0] dq_sync;

  pfcs_sync #(.W(`PFCS_DW)) u_dq_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (flash_dq_i),
    .sync_out (dq_sync)
  );

  // ==========================================================
  // Bus cycle content per step
  reg [2:0]          last_cyc;
  reg [`PFCS_AW-1:0] cyc_addr;
  reg [`PFCS_DW-1:0] cyc_data;
  always @* begin
    // program is four cycles, erases six
    last_cyc = (op_q == `PFCS_OP_PROGRAM) ? 3'h3 : 3'h5;
    cyc_addr = `PFCS_UNLOCK_A1;
    cyc_data = `PFCS_UNLOCK_D1;
    case (cyc_q)
      3'h0: begin
        cyc_addr = `PFCS_UNLOCK_A1;
        cyc_data = `PFCS_UNLOCK_D1;
      end
      3'h1, 3'h4: begin
        cyc_addr = `PFCS_UNLOCK_A2;
        cyc_data = `PFCS_UNLOCK_D2;
      end
      3'h2: begin
        cyc_addr = `PFCS_UNLOCK_A1;
        cyc_data = (op_q == `PFCS_OP_PROGRAM) ? `PFCS_CMD_PROGRAM : `PFCS_CMD_ERASE;
      end
      3'h3: begin
        if (op_q == `PFCS_OP_PROGRAM) begin
          cyc_addr = addr_q;
          cyc_data = data_q;
        end else begin
          cyc_addr = `PFCS_UNLOCK_A1;
          cyc_data = `PFCS_UNLOCK_D1;
        end
      end
      3'h5: begin
        // sector code, block code, chip code at 5555H
        if (op_q == `PFCS_OP_SECTOR) begin
          cyc_addr = addr_q;
          cyc_data = `PFCS_CMD_SECTOR;
        end else if (op_q == `PFCS_OP_BLOCK) begin
          cyc_addr = addr_q;
          cyc_data = `PFCS_CMD_BLOCK;
        end else begin
          cyc_addr = `PFCS_CHIP_ADDR;
          cyc_data = `PFCS_CMD_CHIP;
        end
      end
      default: begin
        cyc_addr = `PFCS_UNLOCK_A1;
        cyc_data = `PFCS_UNLOCK_D1;
      end
    endcase
  end

  // target assumed erased, else only a timeout ends the wait
  // Poll bit matches final state: data for program, one for erase
  wire [`PFCS_DW-1:0] expect_w = (op_q == `PFCS_OP_PROGRAM) ? data_q : {`PFCS_DW{1'b1}};
  // poll bit judged against expected value
  wire poll_done = dq_sync[`PFCS_POLL_BIT] == expect_w[`PFCS_POLL_BIT];
  wire tog_still = prev_ok_q && (dq_sync[`PFCS_TOGGLE_BIT] == prev_q[`PFCS_TOGGLE_BIT]);
  wire done_now  = poll_done && tog_still;

  // ==========================================================
  // Sequencer
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      op_q        <= `PFCS_OP_READ;
      cyc_q       <= 3'h0;
      cnt_q       <= 8'h00;
      tmo_q       <= 32'h0;
      addr_q      <= {`PFCS_AW{1'b0}};
      data_q      <= {`PFCS_DW{1'b0}};
      polling_q   <= 1'b0;
      confirm_q   <= 2'h0;
      prev_q      <= {`PFCS_DW{1'b0}};
      prev_ok_q   <= 1'b0;
      req_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_data    <= {`PFCS_DW{1'b0}};
      rsp_error   <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_addr  <= {`PFCS_AW{1'b0}};
      flash_dq_o  <= {`PFCS_DW{1'b0}};
      flash_dq_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      // Wait limit counts clock cycles, so it maps to time
      if (polling_q) begin
        tmo_q <= tmo_q + 32'h1;
      end
      case (state_q)
        ST_IDLE: begin
          flash_ce_n <= 1'b1;
          req_ready  <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            op_q      <= req_op;
            addr_q    <= req_addr;
            data_q    <= req_data;
            cyc_q     <= 3'h0;
            polling_q <= 1'b0;
            prev_ok_q <= 1'b0;
            confirm_q <= 2'h0;
            tmo_q     <= 32'h0;
            state_q   <= (req_op == `PFCS_OP_READ) ? ST_RSETUP : ST_SETUP;
          end
        end
        ST_SETUP: begin
          // address and data set before strobes fall
          flash_addr  <= cyc_addr;
          flash_dq_o  <= cyc_data;
          flash_dq_oe <= 1'b1;
          flash_oe_n  <= 1'b1;
          cnt_q       <= STROBE_CYC;
          state_q     <= ST_STROBE;
        end
        ST_STROBE: begin
          // write strobe low with chip select low
          flash_ce_n <= 1'b0;
          flash_we_n <= 1'b0;
          cnt_q      <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // strobe rise latches command, data stays this cycle
          flash_we_n <= 1'b1;
          flash_ce_n <= 1'b1;
          if (cyc_q == last_cyc) begin
            state_q <= ST_RSETUP;
            polling_q <= 1'b1;
          end else begin
            cyc_q   <= cyc_q + 3'h1;
            state_q <= ST_SETUP;
          end
        end
        ST_RSETUP: begin
          flash_dq_oe <= 1'b0;
          flash_we_n  <= 1'b1;
          flash_addr  <= addr_q;
          cnt_q       <= READ_CYC;
          state_q     <= ST_RWAIT;
        end
        ST_RWAIT: begin
          flash_ce_n <= 1'b0;
          flash_oe_n <= 1'b0;
          cnt_q      <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            state_q <= polling_q ? ST_POLL : ST_RDONE;
          end
        end
        ST_RDONE: begin
          flash_ce_n <= 1'b1;
          flash_oe_n <= 1'b1;
          rsp_valid  <= 1'b1;
          rsp_data   <= dq_sync;
          rsp_error  <= 1'b0;
          state_q    <= ST_IDLE;
        end
        ST_POLL: begin
          // no commands while busy, only status reads
          flash_ce_n <= 1'b1;
          flash_oe_n <= 1'b1;
          prev_q     <= dq_sync;
          prev_ok_q  <= 1'b1;
          // two further valid reads confirm completion
          if (done_now) begin
            confirm_q <= confirm_q + 2'h1;
          end else begin
            confirm_q <= 2'h0;
          end
          if (done_now && confirm_q == 2'h2) begin
            rsp_error <= 1'b0;
            state_q <= ST_DONE;
          end else if (tmo_q >= TIMEOUT_CYC) begin
            rsp_error <= 1'b1;
            state_q   <= ST_DONE;
          end else begin
            state_q <= ST_RSETUP;
          end
        end
        ST_DONE: begin
          // device back in read mode unless the wait timed out, accept next request
          rsp_valid <= 1'b1;
          rsp_data  <= dq_sync;
          polling_q <= 1'b0;
          state_q   <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // pfcs_host
`default_nettype wire

/* test/pfcs_host_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Pin and handshake checks
module pfcs_host_checker #(
  parameter [31:0] TIMEOUT_CYC = 300
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // User side
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  // Flash pins
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic [18:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_we_with_ce: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("strobe without select");
  a_read_no_drive: assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe)
    else $error("host drives during read");
  a_setup_first: assert property ($fell(flash_we_n) |-> $past(flash_dq_oe) && $stable(flash_addr))
    else $error("no setup before strobe");
  a_hold_after: assert property ($rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o) && $stable(flash_addr))
    else $error("no hold after strobe");
  a_strobe_once: assert property ($fell(flash_we_n) |=> flash_we_n)
    else $error("strobe longer than one cycle");
  a_idle_desel: assert property (req_ready |-> flash_ce_n && flash_oe_n && flash_we_n)
    else $error("pins active in idle");
  a_busy_refuse: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready after take");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than a pulse");
  a_answer_bound: assert property (req_valid && req_ready |-> ##[2:1000] rsp_valid)
    else $error("no answer in time");
endmodule // pfcs_host_checker
bind pfcs_host pfcs_host_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_pfcs_host_checker (.ref_clk, .rst,
  .req_valid, .req_ready, .rsp_valid, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
  .flash_dq_o, .flash_dq_oe);
`default_nettype wire

/* test/pfcs_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Behavioural x16 flash, busy times shortened
module pfcs_flash_model #(
  parameter int PROG_NS  = 3000,
  parameter int ERASE_NS = 10000,
  parameter int CHIP_NS  = 45000
) (
  // Flash pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [18:0] addr,
  input  wire logic [15:0] din,
  output var  logic [15:0] dq
);
  logic [15:0] mem [0:524287];
  logic [18:0] a_q = 19'h00000;
  logic [15:0] pd_q = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic        busy = 1'b0;
  logic        tgl = 1'b0;
  logic        prog = 1'b0;
  int          s = 0;
  wire         wsel = !ce_n && !we_n;
  wire         rsel = !ce_n && !oe_n;
  initial for (int k = 0; k < 524288; k++) mem[k] = 16'hFFFF;
  task automatic start(input int d, input logic p);
    busy = 1'b1;
    prog = p;
    fork
      begin
        #(d);
        busy = 1'b0;
      end
    join_none
  endtask
  task automatic wipe(input int base, input int n);
    for (int k = 0; k < n; k++) mem[base + k] = 16'hFFFF;
  endtask
  always @(posedge wsel) a_q = addr;
  // unlock check at the earlier rise; ignored while busy
  always @(negedge wsel) if (!busy) begin
    case (s)
      0, 3: s = (a_q == 19'h05555 && din == 16'h00AA) ? s + 1 : 0;
      1, 4: s = (a_q == 19'h02AAA && din == 16'h0055) ? s + 1 : 0;
      2: s = (a_q != 19'h05555) ? 0 : (din == 16'h00A0) ? 6 : (din == 16'h0080) ? 3 : 0;
      6: begin
        mem[a_q] = mem[a_q] & din;
        pd_q = din;
        start(PROG_NS, 1'b1);
        s = 0;
      end
      default: begin
        s = 0;
        if (din == 16'h0030) begin
          wipe({a_q[18:11], 11'h000}, 2048);
          start(ERASE_NS, 1'b0);
        end else if (din == 16'h0050) begin
          wipe({a_q[18:15], 15'h0000}, 32768);
          start(ERASE_NS, 1'b0);
        end else if (din == 16'h0010 && a_q == 19'h05555) begin
          wipe(0, 524288);
          start(CHIP_NS, 1'b0);
        end
      end
    endcase
  end
  always @(posedge rsel) if (busy) tgl = !tgl;
  // drive only when gated; released bus shows inverse of last value
  always @(rsel or addr or busy or tgl) begin
    if (rsel) begin
      dq = busy ? {8'h00, prog & ~pd_q[7], tgl, 6'h00} : mem[addr];
      last = dq;
    end else dq = ~last;
  end
endmodule // pfcs_flash_model
`default_nettype wire

/* test/pfcs_host_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pfcs_map.vh"
// ==========================================
// Sequencer bench
module pfcs_host_test;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic [2:0]  req_op = 3'h0;
  logic [18:0] req_addr = 19'h00000;
  logic [15:0] req_data = 16'h0000;
  logic        req_ready, rsp_valid, rsp_error, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
  logic [18:0] flash_addr, a0;
  logic [15:0] rsp_data, flash_dq_o, mdq;
  logic [15:0] ds [4];
  logic [17:0] q [$];
  logic [17:0] e;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  wire  [15:0] flash_dq_i = flash_dq_oe ? flash_dq_o : mdq;
  always #50 ref_clk = ~ref_clk;
  pfcs_host #(.TIMEOUT_CYC(300)) u_pfcs_host (.ref_clk, .rst, .req_valid, .req_op, .req_addr, .req_data,
    .req_ready, .rsp_valid, .rsp_data, .rsp_error, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
    .flash_dq_o, .flash_dq_oe, .flash_dq_i);
  pfcs_flash_model #(.PROG_NS(3000), .ERASE_NS(10000), .CHIP_NS(45000)) u_pfcs_flash_model (
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr), .din(flash_dq_i), .dq(mdq));
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] g, input logic [15:0] x);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("FAIL %0t word %h expected %h", $time, g, x);
    end
  endtask
  task automatic cmp_err(input logic g, input logic x);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("FAIL %0t error flag %b expected %b", $time, g, x);
    end
  endtask
  // Note holds {check data, error, data}
  task automatic req(input logic [2:0] op, input logic [18:0] a, input logic [15:0] d, input logic [17:0] x);
    q.push_back(x);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    @(posedge ref_clk);
    while (req_ready !== 1'b1) @(posedge ref_clk);
    req_valid <= 1'b0;
    while (q.size() != 0) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) if (rsp_valid === 1'b1) begin
    if (q.size() == 0) begin
      fails++;
      $display("FAIL %0t answer without request", $time);
    end
    e = (q.size() != 0) ? q.pop_front() : 18'h3FFFF;
    if (e[17]) cmp_word(rsp_data, e[15:0]);
    cmp_err(rsp_error, e[16]);
  end
  // Ceiling well above the expected one to two thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("FAIL %0t run too long", $time);
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'hBFD8));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    a0 = 19'($urandom);
    req(`PFCS_OP_READ, a0, 16'h0000, {2'b10, 16'hFFFF});
    $display("test read done");
    for (int i = 0; i < 4; i++) begin
      ds[i] = 16'($urandom);
      req(`PFCS_OP_PROGRAM, a0 ^ {i[1:0], 11'h000}, ds[i], {2'b10, ds[i]});
      req(`PFCS_OP_READ, a0 ^ {i[1:0], 11'h000}, 16'h0000, {2'b10, ds[i]});
    end
    $display("test program done");
    req(`PFCS_OP_SECTOR, a0, 16'h0000, {2'b10, 16'hFFFF});
    req(`PFCS_OP_READ, a0, 16'h0000, {2'b10, 16'hFFFF});
    req(`PFCS_OP_READ, a0 ^ 19'h00800, 16'h0000, {2'b10, ds[1]});
    $display("test sector done");
    req(`PFCS_OP_BLOCK, a0, 16'h0000, {2'b10, 16'hFFFF});
    req(`PFCS_OP_READ, a0 ^ 19'h01800, 16'h0000, {2'b10, 16'hFFFF});
    $display("test block done");
    req(`PFCS_OP_PROGRAM, a0, ds[2], {2'b10, ds[2]});
    // chip erase outlasts the wait limit
    req(`PFCS_OP_CHIP, 19'h00000, 16'h0000, {2'b01, 16'h0000});
    // program during chip erase is lost
    req(`PFCS_OP_PROGRAM, a0, ds[0] | 16'h0080, {2'b10, 16'hFFFF});
    req(`PFCS_OP_READ, a0, 16'h0000, {2'b10, 16'hFFFF});
    $display("test chip done");
    tally_and_finish;
  end
endmodule // pfcs_host_test
`default_nettype wire
